//--- bwc_pkg.sv
// Shared constants, register map and state encoding for the wake controller
package bwc_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned TRACK_TICK_MS = 1000;
  localparam int unsigned TRACK_TICK_CYCLES = TRACK_TICK_MS * 1000 * CLK_MHZ;
  localparam int unsigned PPM_SLOT_US = 100;
  localparam int unsigned PPM_SLOT_CYCLES = PPM_SLOT_US * CLK_MHZ;
  localparam int unsigned PPM_PULSE_US = 10;
  localparam int unsigned PPM_PULSE_CYCLES = PPM_PULSE_US * CLK_MHZ;
  localparam int unsigned PPM_BITS = 8;

  // ---------------------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ESTIMATE = 8'h08;
  localparam logic [7:0] ADDR_DIS_STEP = 8'h0C;
  localparam logic [7:0] ADDR_CHG_STEP = 8'h10;
  localparam logic [7:0] ADDR_THRESH = 8'h14;
  localparam logic [7:0] ADDR_BATT = 8'h18;
  localparam logic [7:0] ADDR_RAM_BASE = 8'h20;
  localparam logic [7:0] ADDR_RAM_END = 8'h40;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned CTRL_DBG_EN_BIT = 0;
  localparam int unsigned STAT_CHG_BIT = 4;
  localparam int unsigned STAT_HOST_BIT = 5;
  localparam int unsigned STAT_BLOCK_BIT = 6;
  localparam int unsigned STAT_CUT_BIT = 7;
  localparam logic [15:0] EST_RESET = 16'h8000;
  localparam logic [7:0] DIS_STEP_RESET = 8'h01;
  localparam logic [7:0] CHG_STEP_RESET = 8'h04;
  localparam logic [7:0] THRESH_RESET = 8'h60;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------------------
  // Controller states
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    BWC_STOP = 4'h1,
    BWC_WAKE = 4'h2,
    BWC_UPDATE = 4'h4,
    BWC_TRACK = 4'h8
  } bwc_state_t;

endpackage

//--- bwc_sync.sv
// Two-stage synchroniser for a vector of independent level inputs
`timescale 1ns/10ps
module bwc_sync
#(
  parameter int unsigned W = 1
)
(
  input logic ref_clk,
  input logic reset_n,
  input logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } bwc_sync_st_t;

  bwc_sync_st_t st_q;
  bwc_sync_st_t st_d;

  // First stage feeds only the second stage
  always_comb
  begin
    st_d.stage1 = asyncIn;
    st_d.stage2 = st_q.stage1;
  end

  // State register
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign syncOut = st_q.stage2;

endmodule

//--- bwc_ppm_tx.sv
// Pulse-position serialiser: one byte per start, MSB first
`timescale 1ns/10ps
module bwc_ppm_tx
  import bwc_pkg::*;
#(
  parameter int unsigned SLOT_CYCLES = PPM_SLOT_CYCLES
)
(
  input logic ref_clk,
  input logic reset_n,
  input logic start,
  input logic [7:0] dataIn,
  output logic busy,
  output logic serialOut
);

  // Pulse sits in the first half of the slot for a zero, second half for a one
  localparam logic [15:0] SLOT_LAST = 16'(SLOT_CYCLES - 1);
  localparam logic [15:0] ONE_START = 16'(SLOT_CYCLES / 2);
  localparam logic [15:0] PULSE_LEN = 16'(PPM_PULSE_CYCLES);
  localparam logic [2:0] LAST_BIT = 3'(PPM_BITS - 1);

  typedef struct packed {
    logic busy;
    logic [7:0] shift;
    logic [2:0] bitCnt;
    logic [15:0] slotCnt;
    logic out;
  } bwc_ppm_st_t;

  bwc_ppm_st_t st_q;
  bwc_ppm_st_t st_d;
  logic [15:0] pulseStart;

  // Slot timing and bit shifting
  always_comb
  begin
    st_d = st_q;
    pulseStart = st_q.shift[7] ? ONE_START : 16'h0000;
    st_d.out = st_q.busy && (st_q.slotCnt >= pulseStart)
               && (st_q.slotCnt < pulseStart + PULSE_LEN);
    if (!st_q.busy)
    begin
      if (start)
      begin
        st_d.busy = 1'b1;
        st_d.shift = dataIn;
        st_d.bitCnt = 3'h0;
        st_d.slotCnt = 16'h0000;
      end
    end
    else if (st_q.slotCnt == SLOT_LAST)
    begin
      st_d.slotCnt = 16'h0000;
      st_d.shift = {st_q.shift[6:0], 1'b0};
      if (st_q.bitCnt == LAST_BIT)
        st_d.busy = 1'b0;
      else
        st_d.bitCnt = st_q.bitCnt + 3'h1;
    end
    else
      st_d.slotCnt = st_q.slotCnt + 16'h0001;
  end

  // State register
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign busy = st_q.busy;
  assign serialOut = st_q.out;

endmodule

//--- bwc_wake_control.sv
// Battery controller wake/sleep sequencing, supply enables and register slave
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
// Contract
// - Wake pulse leaves stop, samples both inputs
// - Nothing present: discharge update, back to stop
// - Amp supply off during idle wake cycle
// - Something present: block pulses, track charge
// - Self-discharge tracked whether host runs or not
// - Host switch high closed, sampled periodically
// - Charger input high means charger present
// - Amp supply enable high, off in stop
// - Converter enable high, off at low battery
// - RAM contents sent as pulse-position serial
// - Block output active low, holds timer reset
module bwc_wake_control
  import bwc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TRACK_TICK_CYCLES,
  parameter int unsigned SLOT_CYCLES = PPM_SLOT_CYCLES
)
(
  input logic ref_clk,
  input logic reset_n,
  input logic [7:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  input logic [7:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  input logic wakePulse,
  input logic chargerPresent,
  input logic hostSwitchSense,
  input logic [7:0] batteryLevel,
  output logic ampSupplyEnable,
  output logic converterEnable,
  output logic wakePulseBlock_n,
  output logic debugSerialOut
);

  // ---------------------------------------------------------------------------
  // Local constants
  // ---------------------------------------------------------------------------
  localparam logic [27:0] TICK_LAST = 28'(TICK_CYCLES - 1);
  localparam int unsigned RAM_WORDS = 8;

  // ---------------------------------------------------------------------------
  // State of the whole block
  // ---------------------------------------------------------------------------
  typedef struct packed {
    bwc_state_t state;
    logic blockN;
    logic ampEn;
    logic convEn;
    logic convCut;
    logic cutFlag;
    logic wakePrev;
    logic [27:0] tickCnt;
    logic [15:0] estimate;
    logic [7:0] disStep;
    logic [7:0] chgStep;
    logic [7:0] thresh;
    logic dbgEn;
    logic [RAM_WORDS-1:0][7:0] ram;
    logic [2:0] ramIdx;
    logic ppmStart;
    logic [7:0] ppmData;
    logic awHave;
    logic [7:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } bwc_st_t;

  bwc_st_t st_q;
  bwc_st_t st_d;

  logic [2:0] syncIn;
  logic wakeS;
  logic chgS;
  logic hostS;
  logic ppmBusy;
  logic present;
  logic tick;
  logic [7:0] wAddr;
  logic [7:0] rAddr;
  logic [31:0] wMerged;
  logic [31:0] rdVal;
  logic rdErr;
  logic wrErr;
  logic [16:0] sumEst;

  // ---------------------------------------------------------------------------
  // Input synchronisers and debug serialiser
  // ---------------------------------------------------------------------------
  // Wake, charger and switch pins come from other power domains, so nothing decides on them raw
  bwc_sync #(
    .W(3)
  ) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .asyncIn({wakePulse, chargerPresent, hostSwitchSense}),
    .syncOut(syncIn)
  );

  assign wakeS = syncIn[2];
  assign chgS = syncIn[1];
  assign hostS = syncIn[0];

  bwc_ppm_tx #(
    .SLOT_CYCLES(SLOT_CYCLES)
  ) u_ppm (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .start(st_q.ppmStart),
    .dataIn(st_q.ppmData),
    .busy(ppmBusy),
    .serialOut(debugSerialOut)
  );

  // Either source keeps the controller awake: charger high, switch high
  assign present = chgS || hostS;
  assign tick = (st_q.tickCnt == TICK_LAST);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Byte-lane merge for partial writes
  function automatic logic [31:0] mergeStrb(input logic [31:0] oldV,
                                            input logic [31:0] newV,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = oldV;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = newV[i*8 +: 8];
    end
    return res;
  endfunction

  // Saturating discharge step, never wraps below empty
  function automatic logic [15:0] subSat(input logic [15:0] est,
                                         input logic [7:0] step);
    logic [15:0] res;
    res = 16'h0000;
    if (est > {8'h00, step})
      res = est - {8'h00, step};
    return res;
  endfunction

  // ---------------------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------------------
  always_comb
  begin
    rAddr = {araddr[7:2], 2'b00};
    rdVal = 32'h0000_0000;
    rdErr = 1'b0;
    if (rAddr == ADDR_CTRL)
      rdVal[CTRL_DBG_EN_BIT] = st_q.dbgEn;
    else if (rAddr == ADDR_STATUS)
    begin
      rdVal[3:0] = st_q.state;
      rdVal[STAT_CHG_BIT] = chgS;
      rdVal[STAT_HOST_BIT] = hostS;
      rdVal[STAT_BLOCK_BIT] = ~st_q.blockN;
      rdVal[STAT_CUT_BIT] = st_q.cutFlag;
    end
    else if (rAddr == ADDR_ESTIMATE)
      rdVal[15:0] = st_q.estimate;
    else if (rAddr == ADDR_DIS_STEP)
      rdVal[7:0] = st_q.disStep;
    else if (rAddr == ADDR_CHG_STEP)
      rdVal[7:0] = st_q.chgStep;
    else if (rAddr == ADDR_THRESH)
      rdVal[7:0] = st_q.thresh;
    else if (rAddr == ADDR_BATT)
      rdVal[7:0] = batteryLevel;
    else if ((rAddr >= ADDR_RAM_BASE) && (rAddr < ADDR_RAM_END))
      rdVal[7:0] = st_q.ram[rAddr[4:2]];
    else
      rdErr = 1'b1;
  end

  // ---------------------------------------------------------------------------
  // Sequencer, tracking, debug feed and bus slave
  // ---------------------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.ppmStart = 1'b0;
    st_d.wakePrev = wakeS;
    wAddr = {st_q.awAddr[7:2], 2'b00};
    wMerged = 32'h0000_0000;
    wrErr = 1'b0;
    sumEst = 17'h00000;

    // Tick counter only runs in track mode; stop, wake and update hold it at zero
    if ((st_q.state == BWC_TRACK) && !tick)
      st_d.tickCnt = st_q.tickCnt + 28'h0000001;
    else
      st_d.tickCnt = 28'h0000000;

    case (st_q.state)
      BWC_STOP:
      begin
        st_d.ampEn = 1'b0;
        st_d.convEn = 1'b0;
        st_d.convCut = 1'b0;
        st_d.blockN = 1'b1;
        // Rising edge of the wake pulse leaves stop mode
        if (wakeS && !st_q.wakePrev)
          st_d.state = BWC_WAKE;
      end
      BWC_WAKE:
      begin
        // Single-cycle look at both sense inputs
        if (present)
        begin
          st_d.state = BWC_TRACK;
          st_d.blockN = 1'b0;
          st_d.ampEn = 1'b1;
          st_d.convEn = 1'b1;
        end
        else
          st_d.state = BWC_UPDATE;
      end
      BWC_UPDATE:
      begin
        // Idle cycle: amplifiers stay unpowered to save quiescent current
        st_d.ampEn = 1'b0;
        st_d.estimate = subSat(st_q.estimate, st_q.disStep);
        st_d.state = BWC_STOP;
      end
      BWC_TRACK:
      begin
        st_d.ampEn = 1'b1;
        // Low battery cuts the converter until the next stop
        if (batteryLevel <= st_q.thresh)
        begin
          st_d.convCut = 1'b1;
          st_d.convEn = 1'b0;
        end
        else
          st_d.convEn = ~st_q.convCut;
        if (tick)
        begin
          // Charge credit when the charger is in, self-discharge always
          if (chgS)
          begin
            sumEst = {1'b0, st_q.estimate} + {9'h000, st_q.chgStep};
            st_d.estimate = sumEst[16] ? 16'hFFFF : sumEst[15:0];
          end
          st_d.estimate = subSat(st_d.estimate, st_q.disStep);
          // Periodic scan of the inputs decides when to sleep again
          if (!present)
          begin
            st_d.state = BWC_STOP;
            st_d.blockN = 1'b1;
            st_d.ampEn = 1'b0;
            st_d.convEn = 1'b0;
          end
        end
      end
      default:
      begin
        st_d.state = BWC_STOP;
        st_d.blockN = 1'b1;
        st_d.ampEn = 1'b0;
        st_d.convEn = 1'b0;
      end
    endcase

    // Feed RAM bytes round-robin to the serialiser; wait out its busy flag
    if (st_q.dbgEn && !ppmBusy && !st_q.ppmStart)
    begin
      st_d.ppmStart = 1'b1;
      st_d.ppmData = st_q.ram[st_q.ramIdx];
      st_d.ramIdx = st_q.ramIdx + 3'h1;
    end

    // Address and data channels are taken independently
    if (st_q.awready && awvalid)
    begin
      st_d.awHave = 1'b1;
      st_d.awAddr = awaddr;
      st_d.awready = 1'b0;
    end
    if (st_q.wready && wvalid)
    begin
      st_d.wHave = 1'b1;
      st_d.wData = wdata;
      st_d.wStrb = wstrb;
      st_d.wready = 1'b0;
    end

    // Write once both halves are held; software overrides a same-cycle hardware estimate update
    if (st_q.awHave && st_q.wHave && !st_q.bvalid)
    begin
      if (wAddr == ADDR_CTRL)
      begin
        wMerged = mergeStrb({31'h0, st_q.dbgEn}, st_q.wData, st_q.wStrb);
        st_d.dbgEn = wMerged[CTRL_DBG_EN_BIT];
      end
      else if (wAddr == ADDR_STATUS)
      begin
        // Write one to clear the cut flag
        if (st_q.wStrb[0] && st_q.wData[STAT_CUT_BIT])
          st_d.cutFlag = 1'b0;
      end
      else if (wAddr == ADDR_ESTIMATE)
      begin
        wMerged = mergeStrb({16'h0, st_q.estimate}, st_q.wData, st_q.wStrb);
        st_d.estimate = wMerged[15:0];
      end
      else if (wAddr == ADDR_DIS_STEP)
      begin
        wMerged = mergeStrb({24'h0, st_q.disStep}, st_q.wData, st_q.wStrb);
        st_d.disStep = wMerged[7:0];
      end
      else if (wAddr == ADDR_CHG_STEP)
      begin
        wMerged = mergeStrb({24'h0, st_q.chgStep}, st_q.wData, st_q.wStrb);
        st_d.chgStep = wMerged[7:0];
      end
      else if (wAddr == ADDR_THRESH)
      begin
        wMerged = mergeStrb({24'h0, st_q.thresh}, st_q.wData, st_q.wStrb);
        st_d.thresh = wMerged[7:0];
      end
      else if (wAddr == ADDR_BATT)
        wrErr = 1'b0;
      else if ((wAddr >= ADDR_RAM_BASE) && (wAddr < ADDR_RAM_END))
      begin
        if (st_q.wStrb[0])
          st_d.ram[wAddr[4:2]] = st_q.wData[7:0];
      end
      else
        wrErr = 1'b1;
      st_d.bvalid = 1'b1;
      st_d.bresp = wrErr ? RESP_SLVERR : RESP_OKAY;
      st_d.awHave = 1'b0;
      st_d.wHave = 1'b0;
    end
    if (st_q.bvalid && bready)
    begin
      st_d.bvalid = 1'b0;
      st_d.awready = 1'b1;
      st_d.wready = 1'b1;
    end

    // Converter cut event sets its sticky flag; set beats a same-cycle clear
    if ((st_q.state == BWC_TRACK) && (batteryLevel <= st_q.thresh))
      st_d.cutFlag = 1'b1;

    // Single outstanding read, answered the cycle after the address is taken
    if (st_q.arready && arvalid)
    begin
      st_d.arready = 1'b0;
      st_d.rvalid = 1'b1;
      st_d.rdata = rdVal;
      st_d.rresp = rdErr ? RESP_SLVERR : RESP_OKAY;
    end
    if (st_q.rvalid && rready)
    begin
      st_d.rvalid = 1'b0;
      st_d.arready = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= '0;
      st_q.state <= BWC_STOP;
      st_q.blockN <= 1'b1;
      st_q.estimate <= EST_RESET;
      st_q.disStep <= DIS_STEP_RESET;
      st_q.chgStep <= CHG_STEP_RESET;
      st_q.thresh <= THRESH_RESET;
      st_q.awready <= 1'b1;
      st_q.wready <= 1'b1;
      st_q.arready <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  // ---------------------------------------------------------------------------
  // Outputs, all from flip-flops
  // ---------------------------------------------------------------------------
  assign awready = st_q.awready;
  assign wready = st_q.wready;
  assign bvalid = st_q.bvalid;
  assign bresp = st_q.bresp;
  assign arready = st_q.arready;
  assign rvalid = st_q.rvalid;
  assign rdata = st_q.rdata;
  assign rresp = st_q.rresp;
  assign ampSupplyEnable = st_q.ampEn;
  assign converterEnable = st_q.convEn;
  assign wakePulseBlock_n = st_q.blockN;

endmodule

//--- bwc_wake_control_props.sv
// Port-level checker for the wake controller
`timescale 1ns/10ps
module bwc_wake_control_props
(
  input logic ref_clk,
  input logic reset_n,
  input logic awready,
  input logic wready,
  input logic bvalid,
  input logic bready,
  input logic arready,
  input logic rvalid,
  input logic rready,
  input logic chargerPresent,
  input logic hostSwitchSense,
  input logic ampSupplyEnable,
  input logic converterEnable,
  input logic wakePulseBlock_n
);
  // ------------------------------------------------------------
  // One clock domain, so one default clock and disable
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // Supplies only run while the timer is held off
  a_amp_blocked: assert property (
    ampSupplyEnable |-> !wakePulseBlock_n) else $error("amp supply on while unblocked");
  a_conv_blocked: assert property (
    converterEnable |-> !wakePulseBlock_n) else $error("converter on while unblocked");
  // Blocking needs a present charger or closed switch
  a_block_cause: assert property (
    $fell(wakePulseBlock_n) |-> $past(chargerPresent, 3) || $past(hostSwitchSense, 3))
    else $error("block without cause");
  a_block_amp: assert property (
    $fell(wakePulseBlock_n) |-> ampSupplyEnable) else $error("amp not raised with block");
  a_release_off: assert property (
    $rose(wakePulseBlock_n) |-> !ampSupplyEnable && !converterEnable)
    else $error("supplies left on at release");
  // Release is never taken while an input stays present
  a_block_held: assert property (
    (chargerPresent || hostSwitchSense) [*4] ##0 !wakePulseBlock_n |=> !wakePulseBlock_n)
    else $error("block released early");
  a_write_done: assert property (
    bvalid && bready |=> !bvalid && awready && wready) else $error("write not closed");
  a_read_done: assert property (
    rvalid && rready |=> !rvalid && arready) else $error("read not closed");
endmodule

bind bwc_wake_control bwc_wake_control_props u_props (.ref_clk, .reset_n, .awready,
  .wready, .bvalid, .bready, .arready, .rvalid, .rready, .chargerPresent, .hostSwitchSense,
  .ampSupplyEnable, .converterEnable, .wakePulseBlock_n);

//--- bwc_timer_model.sv
// Behavioural model of the external wake pulse timer
`timescale 1ns/10ps
module bwc_timer_model
#(
  parameter int unsigned PULSE_CYCLES = 20
)
(
  input logic ref_clk,
  input logic timerReset_n,
  input logic fire,
  output logic wakePulse
);
  int unsigned cnt = 0;

  // Pulse length shortened from 10 ms to keep runs brief
  always @(posedge ref_clk)
  begin
    if (timerReset_n !== 1'b1)
      cnt <= 0;
    else if (fire && cnt == 0)
      cnt <= PULSE_CYCLES;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
  assign wakePulse = (cnt != 0);
endmodule

//--- battery_monitor_wake_control_tb.sv
// Self-checking bench for the wake controller
`timescale 1ns/10ps
module battery_monitor_wake_control_tb
  import bwc_pkg::*;
;
  localparam int TICK = 50;
  localparam int SLOT = 4400;
  logic ref_clk = 0, reset_n = 0, fire = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic chargerPresent = 0, hostSwitchSense = 0;
  logic [7:0] awaddr = 0, araddr = 0, batteryLevel = 8'h80;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 0, strb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, wakePulse;
  logic ampSupplyEnable, converterEnable, wakePulseBlock_n, debugSerialOut;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, e0, e1;
  int n_mismatch = 0, cmp_count = 0, w, c;

  bwc_wake_control #(.TICK_CYCLES(TICK), .SLOT_CYCLES(SLOT)) u_dut (.ref_clk, .reset_n,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .wakePulse,
    .chargerPresent, .hostSwitchSense, .batteryLevel, .ampSupplyEnable, .converterEnable,
    .wakePulseBlock_n, .debugSerialOut);
  bwc_timer_model u_timer (.ref_clk, .timerReset_n(wakePulseBlock_n), .fire, .wakePulse);

  // ------------------------------------------------------------
  // Clock, watchdog and reporting
  // ------------------------------------------------------------
  initial forever #2.5 ref_clk = ~ref_clk;
  // Bound near twice the expected run of some 35k cycles
  initial
  begin
    #350000;
    n_mismatch++;
    finish_test();
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task chk_bit(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask
  task finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ------------------------------------------------------------
  // AXI4-Lite master; address and data offered together
  // ------------------------------------------------------------
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw, wd;
    aw = 0;
    wd = 0;
    @(posedge ref_clk);
    awaddr <= a;
    awvalid <= 1;
    wdata <= d;
    wstrb <= strb;
    wvalid <= 1;
    bready <= 1;
    while (!(aw && wd))
    begin
      @(posedge ref_clk);
      if (awvalid && awready === 1'b1)
      begin
        aw = 1;
        awvalid <= 0;
      end
      if (wvalid && wready === 1'b1)
      begin
        wd = 1;
        wvalid <= 0;
      end
    end
    while (bvalid !== 1'b1) @(posedge ref_clk);
    resp = bresp;
    bready <= 0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 0;
    while (rvalid !== 1'b1) @(posedge ref_clk);
    d = rdata;
    resp = rresp;
    rready <= 0;
  endtask
  task rd_chk(input string what, input logic [7:0] a, input logic [31:0] e,
              input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] rs;
    rd(a, d, rs);
    chk(what, e, d);
    chk({what, " resp"}, {30'h0, er}, {30'h0, rs});
  endtask
  // One timer pulse, then time for the wake cycle to settle
  task wake();
    @(posedge ref_clk) fire <= 1;
    @(posedge ref_clk) fire <= 0;
    repeat (40) @(posedge ref_clk);
  endtask
  task blk_wait(input logic v);
    int n;
    n = 0;
    while (wakePulseBlock_n !== v && n < 5 * TICK)
    begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  // Cycles from call to next rising pulse edge; w is the last high width
  task rise_gap();
    c = 0;
    w = 0;
    while (debugSerialOut !== 1'b0 && c < 3 * SLOT)
    begin
      @(posedge ref_clk);
      c++;
      w++;
    end
    while (debugSerialOut !== 1'b1 && c < 3 * SLOT)
    begin
      @(posedge ref_clk);
      c++;
    end
  endtask

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1;
    @(posedge ref_clk);
    chk_bit("amp", 0, ampSupplyEnable);
    chk_bit("conv", 0, converterEnable);
    chk_bit("block", 1, wakePulseBlock_n);
    chk_bit("dbg", 0, debugSerialOut);
    rd_chk("ctrl", ADDR_CTRL, 0, RESP_OKAY);
    rd_chk("status", ADDR_STATUS, 32'h1, RESP_OKAY);
    rd_chk("est", ADDR_ESTIMATE, {16'h0, EST_RESET}, RESP_OKAY);
    rd_chk("dis", ADDR_DIS_STEP, {24'h0, DIS_STEP_RESET}, RESP_OKAY);
    rd_chk("chg", ADDR_CHG_STEP, {24'h0, CHG_STEP_RESET}, RESP_OKAY);
    rd_chk("thr", ADDR_THRESH, {24'h0, THRESH_RESET}, RESP_OKAY);
    // Lane 0 strobed off: the byte-wide threshold keeps its value
    strb = 4'hE;
    wr(ADDR_THRESH, 32'h11, r);
    strb = 4'hF;
    rd_chk("thr strb", ADDR_THRESH, {24'h0, THRESH_RESET}, RESP_OKAY);
    wr(ADDR_BATT, 32'h11, r);
    chk("batt wr", {30'h0, RESP_OKAY}, {30'h0, r});
    rd_chk("batt", ADDR_BATT, 32'h80, RESP_OKAY);
    wr(8'h1C, 32'h5, r);
    chk("unmapped wr", {30'h0, RESP_SLVERR}, {30'h0, r});
    rd_chk("unmapped", 8'h1C, 0, RESP_SLVERR);
    // Idle wake: one discharge step, back to stop
    wake();
    rd_chk("est idle", ADDR_ESTIMATE, 32'h7FFF, RESP_OKAY);
    rd_chk("status idle", ADDR_STATUS, 32'h1, RESP_OKAY);
    chk_bit("amp idle", 0, ampSupplyEnable);
    wr(ADDR_ESTIMATE, 0, r);
    wake();
    rd_chk("est floor", ADDR_ESTIMATE, 0, RESP_OKAY);
    wr(ADDR_ESTIMATE, 32'h100, r);
    // Charger wake: block and track
    chargerPresent <= 1;
    wake();
    blk_wait(0);
    chk_bit("block chg", 0, wakePulseBlock_n);
    chk_bit("amp chg", 1, ampSupplyEnable);
    chk_bit("conv chg", 1, converterEnable);
    rd_chk("status chg", ADDR_STATUS, 32'h58, RESP_OKAY);
    rd(ADDR_ESTIMATE, e0, r);
    repeat (5 * TICK) @(posedge ref_clk);
    rd(ADDR_ESTIMATE, e1, r);
    chk("est step", 0, (e1 - e0) % 3);
    chk_bit("est grew", 1, e1 > e0);
    @(posedge ref_clk) fire <= 1;
    @(posedge ref_clk) fire <= 0;
    @(posedge ref_clk);
    chk_bit("timer held", 0, wakePulse);
    // Low battery cuts the converter until stop
    batteryLevel <= 8'h60;
    repeat (2 * TICK + 5) @(posedge ref_clk);
    chk_bit("conv cut", 0, converterEnable);
    chk_bit("amp cut", 1, ampSupplyEnable);
    batteryLevel <= 8'h80;
    repeat (2 * TICK) @(posedge ref_clk);
    chk_bit("conv latched", 0, converterEnable);
    // Switch alone keeps the block; release when both absent
    hostSwitchSense <= 1;
    chargerPresent <= 0;
    repeat (3 * TICK) @(posedge ref_clk);
    chk_bit("block host", 0, wakePulseBlock_n);
    rd_chk("status host", ADDR_STATUS, 32'hE8, RESP_OKAY);
    hostSwitchSense <= 0;
    blk_wait(1);
    chk_bit("released", 1, wakePulseBlock_n);
    chk_bit("amp rel", 0, ampSupplyEnable);
    wr(ADDR_STATUS, 32'h80, r);
    rd_chk("status rel", ADDR_STATUS, 32'h1, RESP_OKAY);
    hostSwitchSense <= 1;
    wake();
    blk_wait(0);
    chk_bit("block sw", 0, wakePulseBlock_n);
    chk_bit("conv sw", 1, converterEnable);
    hostSwitchSense <= 0;
    blk_wait(1);
    // Debug serial: gaps between pulses follow the byte's bits
    wr(ADDR_RAM_BASE, 32'hA5, r);
    wr(ADDR_CTRL, 32'h1, r);
    rise_gap();
    for (int i = 6; i >= 0; i--)
    begin
      rise_gap();
      chk("ppm gap", SLOT + (8'hA5 >> i & 1) * SLOT / 2 - (8'hA5 >> (i + 1) & 1) * SLOT / 2,
          c);
      chk("ppm width", PPM_PULSE_CYCLES, w);
    end
    finish_test();
  end
endmodule
